// [core/rtc_tx_params.svh]
`ifndef RTC_TX_PARAMS_SVH
`define RTC_TX_PARAMS_SVH

// --------------------------------------------------------------------
// time base
// --------------------------------------------------------------------
`define CLK_HZ        200000000
`define SECOND_S      1
`define CV_EVAL_S     30
`define SEC_PER_MIN   60

// --------------------------------------------------------------------
// value scaling
// --------------------------------------------------------------------
`define PCT_FULL      100
`define CV_FULL       255
`define NUM_CH        4

// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_TEMP_CFG  8'h04
`define OFS_CV_CFG    8'h08
`define OFS_CH_CFG    8'h0C
`define OFS_TEMP_STAT 8'h10
`define OFS_CV_STAT   8'h14
`define OFS_BIT_STAT  8'h18

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define CTRL_REPROG   0
`define CTRL_RD_EN    1
`define CTRL_SENS_LO  2
`define CTRL_COMB     4
`define CH_INV        2

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define RST_CTRL      32'h0000_0000
`define RST_TEMP_CFG  32'h0000_0000
`define RST_CV_CFG    32'h0000_0000
`define RST_CH_CFG    32'h0000_0000

`endif

// [core/rtc_tx_pkg.sv]
package rtc_tx_pkg;

  typedef enum logic [1:0] {
    CT_CONT = 2'b00,
    CT_PWM  = 2'b01,
    CT_TWO  = 2'b10
  } ctrl_type_e;

  typedef enum logic [1:0] {
    SENSE_INT  = 2'b00,
    SENSE_COMB = 2'b01,
    SENSE_EXT  = 2'b10
  } sensor_e;

  typedef enum logic [3:0] {
    OBJ_TEMP  = 4'h0,
    OBJ_BYTE0 = 4'h1,
    OBJ_BIT0  = 4'h5
  } obj_e;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_HOLD = 1'b1
  } tx_state_e;

endpackage : rtc_tx_pkg

// [core/room_temp_command_value_tx.sv]
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_tx_params.svh"

module room_temp_command_value_tx #(
  parameter int unsigned SEC_CYCLES = `CLK_HZ * `SECOND_S
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [15:0]          int_temp_i,
  input  wire logic [15:0]          ext_temp_i,
  input  wire logic                 ext_temp_valid_i,
  input  wire logic                 temp_read_i,
  input  wire logic                 heat_active_i,
  input  wire logic [3:0][6:0]      cv_pct_i,
  input  wire logic [3:0]           sw_req_i,
  output logic                      tx_valid_o,
  output logic      [3:0]           tx_obj_o,
  output logic      [15:0]          tx_data_o,
  output logic                      tx_resp_o,
  input  wire logic                 tx_ready_i
);

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic cyc_due(input logic [7:0] period, input logic [7:0] cnt);
    cyc_due = (period != 8'h00) && (cnt >= period);
  endfunction : cyc_due

  function automatic logic [7:0] enc_cv(input logic [6:0] pct, input logic inv);
    logic [15:0] scaled;
    scaled = (16'(pct) * 16'(`CV_FULL) + 16'(`PCT_FULL / 2)) / 16'(`PCT_FULL);
    enc_cv = inv ? ~scaled[7:0] : scaled[7:0];
  endfunction : enc_cv

  function automatic logic [7:0] min_step(input logic [7:0] cnt, input logic tick,
                                          input logic restart);
    if (restart) begin
      min_step = 8'h00;
    end else if (tick && cnt != 8'hFF) begin
      min_step = cnt + 8'h01;
    end else begin
      min_step = cnt;
    end
  endfunction : min_step

  // ------------------------------------------------------------------
  // time base
  // ------------------------------------------------------------------
  logic [27:0] sec_cnt;
  logic [4:0]  eval_cnt;
  logic [5:0]  min_cnt;
  logic        sec_tick;
  logic        eval_tick;
  logic        min_tick;

  assign sec_tick  = (sec_cnt == 28'(SEC_CYCLES - 1));
  assign eval_tick = sec_tick && (eval_cnt == 5'(`CV_EVAL_S - 1));
  assign min_tick  = sec_tick && (min_cnt == 6'(`SEC_PER_MIN - 1));

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_cnt <= 28'h0000000;
    end else if (sec_tick) begin
      sec_cnt <= 28'h0000000;
    end else begin
      sec_cnt <= sec_cnt + 28'h0000001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      eval_cnt <= 5'h00;
      min_cnt  <= 6'h00;
    end else if (sec_tick) begin
      eval_cnt <= eval_tick ? 5'h00 : eval_cnt + 5'h01;
      min_cnt  <= min_tick ? 6'h00 : min_cnt + 6'h01;
    end
  end

  // ------------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] temp_cfg;
  logic [31:0] cv_cfg;
  logic [31:0] ch_cfg;
  logic        reprog;
  logic        wr_en;
  logic        rd_setup;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [15:0] actual_temp;
  logic [15:0] last_temp;
  logic        ext_seen;
  logic [3:0][7:0] byte_val;
  logic [3:0]  bit_val;
  rtc_tx_pkg::tx_state_e tx_state;

  assign pready_o = 1'b1;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl     <= `RST_CTRL;
      temp_cfg <= `RST_TEMP_CFG;
      cv_cfg   <= `RST_CV_CFG;
      ch_cfg   <= `RST_CH_CFG;
      reprog   <= 1'b0;
    end else begin
      reprog <= wr_en && (paddr_i == `OFS_CTRL) && pwdata_i[`CTRL_REPROG];
      if (wr_en) begin
        case (paddr_i)
          `OFS_CTRL:     ctrl     <= {27'h0000000, pwdata_i[4:1], 1'b0};
          `OFS_TEMP_CFG: temp_cfg <= pwdata_i;
          `OFS_CV_CFG:   cv_cfg   <= {8'h00, pwdata_i[23:0]};
          `OFS_CH_CFG:   ch_cfg   <= pwdata_i & 32'h0707_0707;
          default:       ;
        endcase
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (paddr_i)
      `OFS_CTRL:      rd_mux = ctrl;
      `OFS_TEMP_CFG:  rd_mux = temp_cfg;
      `OFS_CV_CFG:    rd_mux = cv_cfg;
      `OFS_CH_CFG:    rd_mux = ch_cfg;
      `OFS_TEMP_STAT: rd_mux = {last_temp, actual_temp};
      `OFS_CV_STAT:   rd_mux = {byte_val[3], byte_val[2], byte_val[1], byte_val[0]};
      `OFS_BIT_STAT:  rd_mux = {26'h0000000, tx_state == rtc_tx_pkg::TX_HOLD, ext_seen,
                                bit_val};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (rd_setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= !rd_hit;
    end
  end

  // ------------------------------------------------------------------
  // actual temperature
  // ------------------------------------------------------------------
  logic [15:0] ext_temp_q;
  logic [15:0] int_cal;
  logic [15:0] ext_cal;
  logic [16:0] avg_sum;
  logic [16:0] temp_diff;
  logic [16:0] temp_abs;
  logic        temp_changed;
  logic [7:0]  temp_min;
  logic        temp_pend;
  logic        resp_pend;
  logic        load_temp;
  logic        load_resp;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_temp_q <= 16'h0000;
      ext_seen   <= 1'b0;
    end else if (ext_temp_valid_i) begin
      ext_temp_q <= ext_temp_i;
      ext_seen   <= 1'b1;
    end
  end

  assign int_cal = int_temp_i + {{8{temp_cfg[23]}}, temp_cfg[23:16]};
  assign ext_cal = ext_temp_q + {{8{temp_cfg[31]}}, temp_cfg[31:24]};
  assign avg_sum = {int_cal[15], int_cal} + {ext_cal[15], ext_cal};

  always_comb begin
    case (rtc_tx_pkg::sensor_e'(ctrl[`CTRL_SENS_LO +: 2]))
      rtc_tx_pkg::SENSE_COMB: actual_temp = ext_seen ? avg_sum[16:1] : int_cal;
      rtc_tx_pkg::SENSE_EXT:  actual_temp = ext_seen ? ext_cal : 16'h0000;
      default:                actual_temp = int_cal;
    endcase
  end

  assign temp_diff    = {actual_temp[15], actual_temp} - {last_temp[15], last_temp};
  assign temp_abs     = temp_diff[16] ? (17'h00000 - temp_diff) : temp_diff;
  assign temp_changed = (temp_cfg[7:0] != 8'h00) && (temp_abs >= {9'h000, temp_cfg[7:0]});

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_pend <= 1'b1;
      temp_min  <= 8'h00;
      last_temp <= 16'h0000;
      resp_pend <= 1'b0;
    end else begin
      temp_min <= min_step(temp_min, min_tick, load_temp);
      if (load_temp) begin
        last_temp <= actual_temp;
      end
      // only change, period or refresh set it
      if (reprog || (!load_temp && (temp_changed || cyc_due(temp_cfg[15:8], temp_min)))) begin
        temp_pend <= 1'b1;
      end else if (load_temp) begin
        temp_pend <= 1'b0;
      end
      if (temp_read_i && ctrl[`CTRL_RD_EN]) begin
        resp_pend <= 1'b1;
      end else if (load_resp) begin
        resp_pend <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // command value channels
  // ------------------------------------------------------------------
  logic [3:0] pend_byte;
  logic [3:0] pend_bit;
  logic [3:0] load_byte;
  logic [3:0] load_bit;
  logic       combined;

  assign combined = ctrl[`CTRL_COMB];

  genvar k;
  generate
    for (k = 0; k < `NUM_CH; k++) begin : g_ch
      localparam int P = (k >= 2) ? k - 2 : k;
      rtc_tx_pkg::ctrl_type_e ctype;
      logic        inv;
      logic        en;
      logic [6:0]  sat_pct;
      logic [6:0]  pct_now;
      logic [6:0]  pct_next_pwm;
      logic [6:0]  last_pct;
      logic [7:0]  pct_diff;
      logic        sw_bit;
      logic        next_sw;
      logic [7:0]  cyc_min;
      logic [13:0] pwm_sec;
      logic [15:0] period_s;
      logic        pwm_end;
      logic        pwm_on;
      logic        cont_chg;

      // own type, shared type when combined
      assign ctype = rtc_tx_pkg::ctrl_type_e'((combined && k >= 2) ? ch_cfg[8*P +: 2]
                                                                    : ch_cfg[8*k +: 2]);
      assign inv   = ch_cfg[8*k + `CH_INV];
      // only the active direction drives a shared object
      assign en    = !combined || ((k < 2) ? heat_active_i : !heat_active_i);
      assign sat_pct = (cv_pct_i[k] > 7'(`PCT_FULL)) ? 7'(`PCT_FULL) : cv_pct_i[k];

      assign period_s = 16'(cv_cfg[23:16]) * 16'(`SEC_PER_MIN);
      assign pwm_end  = sec_tick && (16'(pwm_sec) + 16'h0001 >= period_s);
      assign pwm_on   = (period_s != 16'h0000) &&
                        (24'(pwm_sec) * 24'(`PCT_FULL) < 24'(pct_now) * 24'(period_s));

      assign pct_diff = (pct_now >= last_pct) ? 8'(pct_now - last_pct)
                                              : 8'(last_pct - pct_now);
      assign cont_chg = (cv_cfg[7:0] != 8'h00) && (pct_diff >= cv_cfg[7:0]);

      always_comb begin
        case (ctype)
          rtc_tx_pkg::CT_PWM: next_sw = pwm_on;
          rtc_tx_pkg::CT_TWO: next_sw = eval_tick ? sw_req_i[k] : sw_bit;
          default:            next_sw = sw_bit;
        endcase
      end

      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pct_now      <= 7'h00;
          pct_next_pwm <= 7'h00;
          pwm_sec      <= 14'h0000;
        end else begin
          if (eval_tick && ctype == rtc_tx_pkg::CT_CONT) begin
            pct_now <= sat_pct;
          end
          if (eval_tick) begin
            pct_next_pwm <= sat_pct;
          end
          if (ctype != rtc_tx_pkg::CT_PWM) begin
            pwm_sec <= 14'h0000;
          end else if (pwm_end) begin
            pwm_sec <= 14'h0000;
            pct_now <= pct_next_pwm;
          end else if (sec_tick) begin
            pwm_sec <= pwm_sec + 14'h0001;
          end
        end
      end

      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          sw_bit    <= 1'b0;
          last_pct  <= 7'h00;
          cyc_min   <= 8'h00;
          pend_byte[k] <= 1'b0;
          pend_bit[k]  <= 1'b0;
        end else begin
          sw_bit  <= next_sw;
          cyc_min <= min_step(cyc_min, min_tick, load_byte[k] || load_bit[k]);
          if (load_byte[k]) begin
            last_pct <= pct_now;
          end
          // no byte unless change or period
          if (en && ((ctype == rtc_tx_pkg::CT_CONT && !load_byte[k] &&
                      (cont_chg || cyc_due(cv_cfg[15:8], cyc_min))) ||
                     (ctype == rtc_tx_pkg::CT_PWM && pwm_end && pct_next_pwm != pct_now))) begin
            pend_byte[k] <= 1'b1;
          end else if (load_byte[k]) begin
            pend_byte[k] <= 1'b0;
          end
          if (en && ((ctype != rtc_tx_pkg::CT_CONT && next_sw != sw_bit) ||
                     (ctype == rtc_tx_pkg::CT_TWO && !load_bit[k] &&
                      cyc_due(cv_cfg[15:8], cyc_min)))) begin
            pend_bit[k] <= 1'b1;
          end else if (load_bit[k]) begin
            pend_bit[k] <= 1'b0;
          end
        end
      end

      assign byte_val[k] = enc_cv(pct_now, inv);
      assign bit_val[k]  = sw_bit ^ inv;
    end
  endgenerate

  // ------------------------------------------------------------------
  // telegram sender
  // ------------------------------------------------------------------
  logic [3:0]  next_obj;
  logic [15:0] next_data;
  logic        any_load;
  int          pick;

  always_comb begin
    load_resp = 1'b0;
    load_temp = 1'b0;
    load_byte = 4'h0;
    load_bit  = 4'h0;
    next_obj  = rtc_tx_pkg::OBJ_TEMP;
    next_data = actual_temp;
    pick      = -1;
    if (tx_state == rtc_tx_pkg::TX_IDLE) begin
      if (resp_pend) begin
        load_resp = 1'b1;
      end else if (temp_pend) begin
        load_temp = 1'b1;
      end else begin
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
          if (pend_bit[i]) begin
            pick = i;
          end
        end
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
          if (pend_byte[i]) begin
            pick = i + `NUM_CH;
          end
        end
        if (pick >= `NUM_CH) begin
          load_byte[pick - `NUM_CH] = 1'b1;
          next_obj  = rtc_tx_pkg::OBJ_BYTE0 + 4'((combined && pick >= `NUM_CH + 2) ?
                                                 pick - `NUM_CH - 2 : pick - `NUM_CH);
          next_data = {8'h00, byte_val[pick - `NUM_CH]};
        end else if (pick >= 0) begin
          load_bit[pick] = 1'b1;
          next_obj  = rtc_tx_pkg::OBJ_BIT0 + 4'((combined && pick >= 2) ? pick - 2 : pick);
          next_data = {15'h0000, bit_val[pick]};
        end
      end
    end
  end

  assign any_load = load_resp || load_temp || (load_byte != 4'h0) || (load_bit != 4'h0);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state   <= rtc_tx_pkg::TX_IDLE;
      tx_valid_o <= 1'b0;
      tx_obj_o   <= 4'h0;
      tx_data_o  <= 16'h0000;
      tx_resp_o  <= 1'b0;
    end else begin
      case (tx_state)
        rtc_tx_pkg::TX_IDLE: begin
          if (any_load) begin
            tx_state   <= rtc_tx_pkg::TX_HOLD;
            tx_valid_o <= 1'b1;
            tx_obj_o   <= next_obj;
            tx_data_o  <= next_data;
            tx_resp_o  <= load_resp;
          end
        end
        rtc_tx_pkg::TX_HOLD: begin
          if (tx_ready_i) begin
            tx_state   <= rtc_tx_pkg::TX_IDLE;
            tx_valid_o <= 1'b0;
          end
        end
        default: begin
          tx_state   <= rtc_tx_pkg::TX_IDLE;
          tx_valid_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : room_temp_command_value_tx

`default_nettype wire

// [test/rtc_tx_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_tx_checker #(
  parameter int unsigned SEC_CYCLES = 10
) (
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pwrite_i,
  input wire logic [7:0]      paddr_i,
  input wire logic [31:0]     pwdata_i,
  input wire logic [31:0]     prdata_o,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  input wire logic [15:0]     int_temp_i,
  input wire logic [15:0]     ext_temp_i,
  input wire logic            ext_temp_valid_i,
  input wire logic            temp_read_i,
  input wire logic            heat_active_i,
  input wire logic [3:0][6:0] cv_pct_i,
  input wire logic [3:0]      sw_req_i,
  input wire logic            tx_valid_o,
  input wire logic [3:0]      tx_obj_o,
  input wire logic [15:0]     tx_data_o,
  input wire logic            tx_resp_o,
  input wire logic            tx_ready_i
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------------
  // telegram port
  // --------------------------------------------------------------------
  a_reset_send: assert property ($past(rst_i) |=> tx_valid_o && tx_obj_o == 4'h0)
    else $error("no temperature telegram after reset");
  a_reprog_send: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h00
    && pwdata_i[0] |-> ##[1:40] tx_valid_o && tx_obj_o == 4'h0 && !tx_resp_o)
    else $error("no temperature telegram after reprogram");
  a_hold_telegram: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_obj_o) && $stable(tx_data_o) && $stable(tx_resp_o))
    else $error("telegram changed before accept");
  a_gap_accept: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no idle cycle after accept");
  a_resp_temp: assert property (tx_valid_o && tx_resp_o |-> tx_obj_o == 4'h0)
    else $error("read answer not temperature");
  a_bit_format: assert property (tx_valid_o && tx_obj_o >= 4'h5 |-> tx_obj_o <= 4'h8
    && tx_data_o[15:1] == 15'h0000) else $error("bad bit telegram");
  a_byte_format: assert property (tx_valid_o && tx_obj_o inside {[4'h1:4'h4]}
    |-> tx_data_o[15:8] == 8'h00) else $error("bad byte telegram");
  // --------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------
  a_apb_err: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0
    |-> pready_o && pslverr_o == (paddr_i > 8'h18)) else $error("bad slave error");
  a_write_zero: assert property (psel_i && penable_i && pwrite_i |-> prdata_o == 32'h0)
    else $error("read data on write");
  c_read_answer: cover property (tx_valid_o && tx_ready_i && tx_resp_o);
  c_byte_sent: cover property (tx_valid_o && tx_ready_i && tx_obj_o == 4'h1);
  c_bit_sent: cover property (tx_valid_o && tx_ready_i && tx_obj_o >= 4'h5);
endmodule : rtc_tx_checker
bind room_temp_command_value_tx rtc_tx_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .int_temp_i(int_temp_i),
  .ext_temp_i(ext_temp_i), .ext_temp_valid_i(ext_temp_valid_i), .temp_read_i(temp_read_i),
  .heat_active_i(heat_active_i), .cv_pct_i(cv_pct_i), .sw_req_i(sw_req_i),
  .tx_valid_o(tx_valid_o), .tx_obj_o(tx_obj_o), .tx_data_o(tx_data_o),
  .tx_resp_o(tx_resp_o), .tx_ready_i(tx_ready_i)
);
`default_nettype wire

// [test/rtc_tx_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_tx_bus_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        tx_valid_i,
  input  wire logic [3:0]  tx_obj_i,
  input  wire logic [15:0] tx_data_i,
  input  wire logic        tx_resp_i,
  output logic             tx_ready_o,
  output logic [15:0]      n_tel_o,
  output logic [3:0]       obj_o,
  output logic [15:0]      data_o,
  output logic             resp_o
);
  logic [1:0] div;
  // --------------------------------------------------------------------
  // actuator side: prompt or slow accept
  // --------------------------------------------------------------------
  assign tx_ready_o = slow_i ? (div == 2'h3) : 1'b1;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 2'h0;
      n_tel_o <= 16'h0000;
      obj_o <= 4'h0;
      data_o <= 16'h0000;
      resp_o <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
        n_tel_o <= n_tel_o + 16'h0001;
        obj_o <= tx_obj_i;
        data_o <= tx_data_i;
        resp_o <= tx_resp_i;
      end
    end
  end
endmodule : rtc_tx_bus_model
`default_nettype wire

// [test/test_room_temp_command_value_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module test_room_temp_command_value_tx;
  localparam int unsigned SEC = 10;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, e, tx_valid_o, tx_resp_o, tx_ready_i, l_resp, slow = 1'b0;
  logic ext_temp_valid_i = 1'b0, temp_read_i = 1'b0, heat_active_i = 1'b1;
  logic [15:0] int_temp_i = 16'h00D7, ext_temp_i = 16'h0000, tx_data_o, l_data, n_tel, c;
  logic [3:0][6:0] cv_pct_i = '0;
  logic [3:0] sw_req_i = 4'h0, tx_obj_o, l_obj;
  int mismatches = 0, n_checks = 0, w;
  always #2.5 sys_clk_i = ~sys_clk_i;
  room_temp_command_value_tx #(.SEC_CYCLES(SEC)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .int_temp_i(int_temp_i), .ext_temp_i(ext_temp_i), .ext_temp_valid_i(ext_temp_valid_i),
    .temp_read_i(temp_read_i), .heat_active_i(heat_active_i), .cv_pct_i(cv_pct_i),
    .sw_req_i(sw_req_i), .tx_valid_o(tx_valid_o), .tx_obj_o(tx_obj_o),
    .tx_data_o(tx_data_o), .tx_resp_o(tx_resp_o), .tx_ready_i(tx_ready_i));
  rtc_tx_bus_model bus (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_obj_i(tx_obj_o), .tx_data_i(tx_data_o),
    .tx_resp_i(tx_resp_o), .tx_ready_o(tx_ready_i), .n_tel_o(n_tel), .obj_o(l_obj),
    .data_o(l_data), .resp_o(l_resp));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic fail(input string nm);
    mismatches++;
    $display("[FAIL] %s expected done seen timeout", nm);
    tally_and_finish();
  endtask : fail
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k == 50) fail("apb");
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb
  task automatic wait_tel(input int lim);
    w = 0;
    while (n_tel == c) begin
      @(posedge sys_clk_i);
      w++;
      if (w > lim) fail("telegram");
    end
    c = n_tel;
  endtask : wait_tel
  task automatic t_reset();
    c = 16'h0000;
    wait_tel(20);
    chk("obj", 32'(l_obj), 32'h0);
    chk("temp", 32'(l_data), 32'h00D7);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reg", q, 32'h0);
      chk("err", 32'(e), 32'h0);
    end
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_quiet();
    c = n_tel;
    int_temp_i <= 16'h0109;
    cv_pct_i[0] <= 7'h64;
    repeat (700) @(posedge sys_clk_i);
    chk("count", 32'(n_tel), 32'(c));
    apb(1'b0, 8'h14, 32'h0);
    chk("cv byte", 32'(q[7:0]), 32'hFF);
    $display("t_quiet done");
  endtask : t_quiet
  task automatic t_change();
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h0003_0005);
    wait_tel(40);
    chk("calib temp", 32'(l_data), 32'h010C);
    int_temp_i <= 16'h010D;
    repeat (40) @(posedge sys_clk_i);
    chk("count", 32'(n_tel), 32'(c));
    int_temp_i <= 16'h010E;
    wait_tel(40);
    chk("step temp", 32'(l_data), 32'h0111);
    slow <= 1'b0;
    apb(1'b1, 8'h04, 32'h0003_0100);
    c = n_tel;
    wait_tel(1300);
    wait_tel(1300);
    chk("period", 32'(w >= 595 && w <= 610), 32'h1);
    apb(1'b1, 8'h04, 32'h0003_0000);
    $display("t_change done");
  endtask : t_change
  task automatic t_read();
    apb(1'b1, 8'h00, 32'h0000_0002);
    c = n_tel;
    temp_read_i <= 1'b1;
    @(posedge sys_clk_i);
    temp_read_i <= 1'b0;
    wait_tel(20);
    chk("resp", 32'(l_resp), 32'h1);
    chk("read temp", 32'(l_data), 32'h0111);
    apb(1'b1, 8'h00, 32'h0000_0007);
    wait_tel(20);
    chk("resp", 32'(l_resp), 32'h0);
    chk("comb temp", 32'(l_data), 32'h0111);
    apb(1'b1, 8'h00, 32'h0000_000A);
    apb(1'b0, 8'h10, 32'h0);
    chk("ext none", 32'(q[15:0]), 32'h0);
    ext_temp_i <= 16'h0105;
    ext_temp_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    ext_temp_valid_i <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk("ext temp", 32'(q[15:0]), 32'h0105);
    apb(1'b1, 8'h00, 32'h0000_0006);
    apb(1'b0, 8'h10, 32'h0);
    chk("avg temp", 32'(q[15:0]), 32'h010B);
    $display("t_read done");
  endtask : t_read
  task automatic t_cont();
    apb(1'b1, 8'h0C, 32'h0000_0400);
    c = n_tel;
    apb(1'b1, 8'h08, 32'h0000_000A);
    wait_tel(700);
    chk("obj", 32'(l_obj), 32'h1);
    chk("cv", 32'(l_data), 32'h00FF);
    repeat (700) @(posedge sys_clk_i);
    c = n_tel;
    cv_pct_i[0] <= 7'h5F;
    repeat (700) @(posedge sys_clk_i);
    chk("count", 32'(n_tel), 32'(c));
    cv_pct_i[0] <= 7'h5A;
    wait_tel(700);
    chk("obj", 32'(l_obj), 32'h1);
    chk("cv step", 32'(l_data), 32'h00E6);
    apb(1'b0, 8'h14, 32'h0);
    chk("inv cv", 32'(q[15:8]), 32'hFF);
    $display("t_cont done");
  endtask : t_cont
  task automatic t_two();
    sw_req_i <= 4'hC;
    apb(1'b1, 8'h0C, 32'h0602_0400);
    repeat (700) @(posedge sys_clk_i);
    apb(1'b0, 8'h18, 32'h0);
    chk("bits", 32'(q[3:2]), 32'h1);
    chk("bit obj", 32'(l_obj), 32'h8);
    chk("bit data", 32'(l_data), 32'h0);
    $display("t_two done");
  endtask : t_two
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_quiet();
    t_change();
    t_read();
    t_cont();
    t_two();
    tally_and_finish();
  end
endmodule : test_room_temp_command_value_tx
`default_nettype wire
